// ===== e1rf_framer_ctrl.sv
`timescale 1ns/1ps
// How it works
// - crc multiframe enable starts search; when off, crc statuses and irqs read 0
// - signaling multiframe disable stops search and zeroes its loss and error
// - in interworking, crc search stops unless keep-search control is set
// - rising edge of force-reframe resyncs; software clears it before reuse
// - 915 crc errors in one second reframe only when that enable is set
// - reframe lock ignores error criteria once aligned; forced reframe still works
// - AIS is detected only while out of frame
// - bit two criterion adds loss after three consecutive nfas bit two errors
// - signaling loss on two errored patterns, or all-zero slot 16 if selected
// - all-zero slot 16 span is one multiframe, or two when span bit set
// - remote alarm on any A=1, or four consecutive; any A=0 clears
// - AIS mode 0: out of frame and a 512-bit period under 3 zeros
// - AIS mode 1: two low periods declare, two periods with 3+ zeros clear
// - excess crc flag sets at 915 errors per second, clears on read
// - four enables raise interrupt on every change of matching status
// - alignment change enable raises interrupt on frame position change
// - frame error enable raises interrupt on errored alignment signal
// - control and enable registers held reset in non-E1 or unframed mode
// - signaling and crc multiframe pattern errors each have an interrupt enable
module e1rf_framer_ctrl
  import e1rf_pkg::*;
#(
  parameter int SEC_CNT = SEC_CYCLES
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // global mode
  input  wire logic       line_standard_select,
  input  wire logic       unframed_select,
  // microprocessor port
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata_q,
  output logic            data_oe_n_q,
  output logic            irq_n_q,
  // events from the receive datapath
  input  wire logic       frame_found,
  input  wire logic       align_moved,
  input  wire logic       fas_check,
  input  wire logic       fas_err,
  input  wire logic       nfas_check,
  input  wire logic       bit2_err,
  input  wire logic       a_bit_check,
  input  wire logic       a_bit,
  input  wire logic       smf_check,
  input  wire logic       smf_err,
  input  wire logic       ts16_zero,
  input  wire logic       smf_found,
  input  wire logic       cmf_check,
  input  wire logic       cmf_err,
  input  wire logic       cmf_found,
  input  wire logic       crc_error,
  input  wire logic       interwork_detect,
  input  wire logic       bit_valid,
  input  wire logic       bit_data,
  // controls and status to the datapath
  output logic            reframe_q,
  output logic            crc_mf_search_q,
  output logic            sig_mf_search_q,
  output logic            out_of_frame_q,
  output logic            remote_alarm_state_q,
  output logic            ais_q
);

  logic       frm_rst;
  logic [7:0] align_q;
  logic [7:0] maint_q;
  logic [7:0] irq_en_q;
  logic [7:0] ind_q;
  logic       wr_prev_q;
  logic       rd_prev_q;
  logic       wr_stb;
  logic       rd_stb;
  logic       force_reframe_prev_q;
  logic [1:0] fas_cnt_q;
  logic [1:0] bit2_cnt_q;
  logic [1:0] smf_cnt_q;
  logic [1:0] ts16_cnt_q;
  logic [2:0] rai_cnt_q;
  logic       smf_oof_q;
  logic       cmf_oof_q;
  logic       iw_q;
  logic [3:0] stat_prev_q;
  logic       crc_excess_pulse;
  logic       crc_excess_flag;
  logic       crc_en;
  logic       sig_dis;
  logic       force_edge;
  logic       fas_loss;
  logic       bit2_loss;
  logic       err_reframe;
  logic       smf_loss;
  logic [1:0] ts16_need;
  logic [3:0] stat_now;
  logic [7:0] ind_set;
  logic [7:0] rd_mux;

  function automatic logic [1:0] sat_inc(input logic [1:0] v,
                                         input logic [1:0] top);
    sat_inc = (v == top) ? v : v + 2'd1;
  endfunction : sat_inc

  // registers stay at their reset values while the framer is not in use
  assign frm_rst = reset || !line_standard_select || unframed_select;
  assign crc_en  = align_q[CRC_MF_EN_BIT];
  assign sig_dis = align_q[SIG_MF_DIS_BIT];

  // bus strobes act once per access, on the cycle the strobe arrives
  assign wr_stb = !cs_n && !wr_n && !wr_prev_q;
  assign rd_stb = !cs_n && !rd_n && !rd_prev_q;

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
    end
    else
    begin
      wr_prev_q <= !cs_n && !wr_n;
      rd_prev_q <= !cs_n && !rd_n;
    end
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst)
    begin
      align_q  <= ALIGN_OPT_RST;
      maint_q  <= MAINT_OPT_RST;
      irq_en_q <= IRQ_EN_RST;
    end
    else if (wr_stb)
    begin
      if (addr == ALIGN_OPT_ADDR)
        align_q  <= wdata & ALIGN_OPT_WMASK;
      if (addr == MAINT_OPT_ADDR)
        maint_q  <= wdata & MAINT_OPT_WMASK;
      if (addr == IRQ_EN_ADDR)
        irq_en_q <= wdata;
    end
  end

  // reframe triggers
  always_ff @(posedge clk)
  begin
    if (frm_rst)
      force_reframe_prev_q <= 1'b0;
    else
      force_reframe_prev_q <= align_q[FORCE_FORCE_REFRAME_BIT];
  end

  assign force_edge = align_q[FORCE_FORCE_REFRAME_BIT] && !force_reframe_prev_q;
  assign fas_loss   = fas_check && fas_err &&
                      (sat_inc(fas_cnt_q, FAS_LOSS_CNT) == FAS_LOSS_CNT);
  assign bit2_loss  = maint_q[BIT2_CRIT_BIT] && nfas_check && bit2_err &&
                      (sat_inc(bit2_cnt_q, BIT2_LOSS_CNT) == BIT2_LOSS_CNT);
  // lock keeps alignment against every error criterion
  assign err_reframe = !align_q[FORCE_REFRAME_LOCK_BIT] && !out_of_frame_q &&
                       (fas_loss || bit2_loss ||
                        (crc_excess_pulse && align_q[CRC_FORCE_REFRAME_EN_BIT]));

  always_ff @(posedge clk)
  begin
    if (frm_rst)
      fas_cnt_q <= '0;
    else if (out_of_frame_q)
      fas_cnt_q <= '0;
    else if (fas_check)
      fas_cnt_q <= fas_err ? sat_inc(fas_cnt_q, FAS_LOSS_CNT) : 2'd0;
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst || out_of_frame_q || !maint_q[BIT2_CRIT_BIT])
      bit2_cnt_q <= '0;
    else if (nfas_check)
      bit2_cnt_q <= bit2_err ? sat_inc(bit2_cnt_q, BIT2_LOSS_CNT) : 2'd0;
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst)
      reframe_q <= 1'b0;
    else
      reframe_q <= force_edge || err_reframe;
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst)
      out_of_frame_q <= 1'b1;
    else if (force_edge || err_reframe)
      out_of_frame_q <= 1'b1;
    else if (frame_found)
      out_of_frame_q <= 1'b0;
  end

  // signaling multiframe
  assign ts16_need = maint_q[TS16_SPAN_BIT] ? TS16_SPAN_TWO :
                     TS16_SPAN_ONE;
  assign smf_loss  = smf_check &&
                     ((smf_err &&
                       sat_inc(smf_cnt_q, SMF_LOSS_CNT) == SMF_LOSS_CNT) ||
                      (maint_q[SMF_EXTRA_BIT] && ts16_zero &&
                       sat_inc(ts16_cnt_q, TS16_SPAN_TWO) >= ts16_need));

  always_ff @(posedge clk)
  begin
    if (frm_rst || smf_oof_q)
    begin
      smf_cnt_q  <= '0;
      ts16_cnt_q <= '0;
    end
    else if (smf_check)
    begin
      smf_cnt_q  <= smf_err ? sat_inc(smf_cnt_q, SMF_LOSS_CNT) : 2'd0;
      ts16_cnt_q <= ts16_zero ? sat_inc(ts16_cnt_q, TS16_SPAN_TWO) : 2'd0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst || sig_dis)
      smf_oof_q <= 1'b0;
    else if (out_of_frame_q || smf_loss)
      smf_oof_q <= 1'b1;
    else if (smf_found)
      smf_oof_q <= 1'b0;
  end

  // crc multiframe and interworking
  always_ff @(posedge clk)
  begin
    if (frm_rst || !crc_en)
    begin
      cmf_oof_q <= 1'b0;
      iw_q      <= 1'b0;
    end
    else
    begin
      iw_q <= interwork_detect;
      if (out_of_frame_q)
        cmf_oof_q <= 1'b1;
      else if (cmf_found)
        cmf_oof_q <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst)
    begin
      crc_mf_search_q <= 1'b0;
      sig_mf_search_q <= 1'b0;
    end
    else
    begin
      crc_mf_search_q <= crc_en && cmf_oof_q && !out_of_frame_q &&
                         !(iw_q && !align_q[IW_KEEP_BIT]);
      sig_mf_search_q <= !sig_dis && smf_oof_q && !out_of_frame_q;
    end
  end

  // remote alarm
  always_ff @(posedge clk)
  begin
    if (frm_rst)
    begin
      rai_cnt_q            <= '0;
      remote_alarm_state_q <= 1'b0;
    end
    else if (a_bit_check)
    begin
      if (!a_bit)
      begin
        rai_cnt_q            <= '0;
        remote_alarm_state_q <= 1'b0;
      end
      else
      begin
        if (rai_cnt_q != RAI_PERSIST)
          rai_cnt_q <= rai_cnt_q + 3'd1;
        if (!maint_q[RAI_PERSIST_BIT] ||
            rai_cnt_q >= RAI_PERSIST - 3'd1)
          remote_alarm_state_q <= 1'b1;
      end
    end
  end

  e1rf_ais_detect u_ais (
    .clk             (clk),
    .reset           (frm_rst),
    .bit_valid       (bit_valid),
    .bit_data        (bit_data),
    .two_period_mode (maint_q[AIS_CRIT_BIT]),
    .out_of_frame    (out_of_frame_q),
    .ais_q           (ais_q)
  );

  e1rf_crc_excess #(
    .WINDOW_CYCLES (SEC_CNT),
    .ERR_LIMIT     (CRC_EXCESS_LIM)
  ) u_crc_excess (
    .clk            (clk),
    .reset          (frm_rst || !crc_en),
    .crc_error      (crc_error),
    .flag_read      (rd_stb && addr == MAINT_OPT_ADDR),
    .excess_pulse_q (crc_excess_pulse),
    .flag_q         (crc_excess_flag)
  );

  // interrupt indications
  assign stat_now = {iw_q, out_of_frame_q, smf_oof_q, cmf_oof_q};

  always_ff @(posedge clk)
  begin
    // reset status is out of frame only, so no false change after reset
    if (frm_rst)
      stat_prev_q <= {1'b0, 1'b1, 1'b0, 1'b0};
    else
      stat_prev_q <= stat_now;
  end

  always_comb
  begin
    ind_set = '0;
    ind_set[IW_IRQ_BIT]       = stat_now[3] ^ stat_prev_q[3];
    ind_set[OOF_IRQ_BIT]      = stat_now[2] ^ stat_prev_q[2];
    ind_set[SMF_LOSS_IRQ_BIT] = stat_now[1] ^ stat_prev_q[1];
    ind_set[CMF_LOSS_IRQ_BIT] = stat_now[0] ^ stat_prev_q[0];
    ind_set[ALIGN_IRQ_BIT]    = align_moved;
    ind_set[FER_IRQ_BIT]      = fas_check && fas_err;
    ind_set[SMF_ERR_IRQ_BIT]  = smf_check && smf_err && !sig_dis;
    ind_set[CMF_ERR_IRQ_BIT]  = cmf_check && cmf_err && crc_en;
  end

  // new events win over the clearing read
  always_ff @(posedge clk)
  begin
    if (frm_rst)
      ind_q <= '0;
    else if (rd_stb && addr == IRQ_IND_ADDR)
      ind_q <= ind_set;
    else
      ind_q <= ind_q | ind_set;
  end

  always_ff @(posedge clk)
  begin
    if (frm_rst)
      irq_n_q <= 1'b1;
    else
      irq_n_q <= !(|(ind_q & irq_en_q));
  end

  // register reads
  always_comb
  begin
    rd_mux = '0;
    case (addr)
      ALIGN_OPT_ADDR:  rd_mux = align_q;
      MAINT_OPT_ADDR:  rd_mux = maint_q | {7'h00, crc_excess_flag};
      IRQ_EN_ADDR:     rd_mux = irq_en_q;
      IRQ_IND_ADDR:    rd_mux = ind_q;
      FRM_STAT_ADDR:   rd_mux = {stat_now, 4'h0};
      ALARM_STAT_ADDR:
      begin
        rd_mux[RAI_STAT_BIT] = remote_alarm_state_q;
        rd_mux[AIS_STAT_BIT] = ais_q;
      end
      default:         rd_mux = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata_q     <= '0;
      data_oe_n_q <= 1'b1;
    end
    else
    begin
      data_oe_n_q <= !(!cs_n && !rd_n);
      if (rd_stb)
        rdata_q <= rd_mux;
    end
  end

endmodule : e1rf_framer_ctrl

// ===== e1rf_pkg.sv
package e1rf_pkg;

  // register offsets
  localparam logic [7:0] ALIGN_OPT_ADDR  = 8'h90;
  localparam logic [7:0] MAINT_OPT_ADDR  = 8'h91;
  localparam logic [7:0] IRQ_EN_ADDR     = 8'h92;
  localparam logic [7:0] IRQ_IND_ADDR    = 8'h94;
  localparam logic [7:0] FRM_STAT_ADDR   = 8'h96;
  localparam logic [7:0] ALARM_STAT_ADDR = 8'h97;

  // reset values
  localparam logic [7:0] ALIGN_OPT_RST = 8'h82;
  localparam logic [7:0] MAINT_OPT_RST = 8'h40;
  localparam logic [7:0] IRQ_EN_RST    = 8'h00;

  // frame alignment options fields
  localparam int CRC_MF_EN_BIT    = 7;
  localparam int SIG_MF_DIS_BIT   = 6;
  localparam int IW_KEEP_BIT      = 5;
  localparam int FORCE_FORCE_REFRAME_BIT   = 2;
  localparam int CRC_FORCE_REFRAME_EN_BIT  = 1;
  localparam int FORCE_REFRAME_LOCK_BIT    = 0;
  localparam logic [7:0] ALIGN_OPT_WMASK = 8'hef;

  // maintenance options fields
  localparam int BIT2_CRIT_BIT    = 6;
  localparam int SMF_EXTRA_BIT    = 5;
  localparam int TS16_SPAN_BIT    = 4;
  localparam int RAI_PERSIST_BIT  = 3;
  localparam int AIS_CRIT_BIT     = 1;
  localparam int CRC_EXCESS_BIT   = 0;
  localparam logic [7:0] MAINT_OPT_WMASK = 8'h7a;

  // interrupt enable / indication fields
  localparam int IW_IRQ_BIT       = 7;
  localparam int OOF_IRQ_BIT      = 6;
  localparam int SMF_LOSS_IRQ_BIT = 5;
  localparam int CMF_LOSS_IRQ_BIT = 4;
  localparam int ALIGN_IRQ_BIT    = 3;
  localparam int FER_IRQ_BIT      = 2;
  localparam int SMF_ERR_IRQ_BIT  = 1;
  localparam int CMF_ERR_IRQ_BIT  = 0;

  // alarm status fields
  localparam int RAI_STAT_BIT     = 7;
  localparam int AIS_STAT_BIT     = 2;

  // criteria counts
  localparam logic [1:0] FAS_LOSS_CNT   = 2'd3;
  localparam logic [1:0] BIT2_LOSS_CNT  = 2'd3;
  localparam logic [1:0] SMF_LOSS_CNT   = 2'd2;
  localparam logic [1:0] TS16_SPAN_ONE  = 2'd1;
  localparam logic [1:0] TS16_SPAN_TWO  = 2'd2;
  localparam logic [2:0] RAI_PERSIST    = 3'd4;
  localparam int         AIS_PERIOD     = 512;
  localparam logic [1:0] AIS_MIN_ZEROS  = 2'd3;
  localparam logic [1:0] AIS_RUN        = 2'd2;
  localparam int         CRC_EXCESS_LIM = 915;

  // one second of clock cycles
  localparam int CLK_PERIOD_NS = 25;
  localparam int ONE_SEC_NS    = 1_000_000_000;
  localparam int SEC_CYCLES    = ONE_SEC_NS / CLK_PERIOD_NS;

endpackage : e1rf_pkg

// ===== e1rf_ais_detect.sv
`timescale 1ns/1ps
module e1rf_ais_detect
  import e1rf_pkg::*;
#(
  parameter int PERIOD_BITS = AIS_PERIOD
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // received bit stream
  input  wire logic bit_valid,
  input  wire logic bit_data,
  // control
  input  wire logic two_period_mode,
  input  wire logic out_of_frame,
  // result
  output logic      ais_q
);

  localparam int CW = $clog2(PERIOD_BITS);

  logic [CW-1:0] bit_cnt_q;
  logic [1:0]    zero_cnt_q;
  logic [1:0]    low_run_q;
  logic [1:0]    high_run_q;
  logic          period_end;
  logic          period_low;

  assign period_end = bit_valid && (bit_cnt_q == CW'(PERIOD_BITS - 1));
  // the ending bit itself may be the third zero
  assign period_low = ((zero_cnt_q == AIS_MIN_ZEROS) ? 1'b0 :
                       (zero_cnt_q + 2'(!bit_data)) != AIS_MIN_ZEROS);

  always_ff @(posedge clk)
  begin
    if (reset || period_end)
      bit_cnt_q <= '0;
    else if (bit_valid)
      bit_cnt_q <= bit_cnt_q + CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset || period_end)
      zero_cnt_q <= '0;
    else if (bit_valid && !bit_data && zero_cnt_q != AIS_MIN_ZEROS)
      zero_cnt_q <= zero_cnt_q + 2'd1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      low_run_q  <= '0;
      high_run_q <= '0;
    end
    else if (period_end)
    begin
      low_run_q  <= period_low ? ((low_run_q == AIS_RUN) ? low_run_q :
                                  low_run_q + 2'd1) : 2'd0;
      high_run_q <= period_low ? 2'd0 : ((high_run_q == AIS_RUN) ?
                                  high_run_q : high_run_q + 2'd1);
    end
  end

  // declaration only while out of frame; once declared, AIS holds after lock until a clearing period
  always_ff @(posedge clk)
  begin
    if (reset)
      ais_q <= 1'b0;
    else if (period_end)
    begin
      if (!two_period_mode)
      begin
        if (period_low && out_of_frame)
          ais_q <= 1'b1;
        else if (!period_low)
          ais_q <= 1'b0;
      end
      else
      begin
        if (period_low && low_run_q != 2'd0 && out_of_frame)
          ais_q <= 1'b1;
        else if (!period_low && high_run_q != 2'd0)
          ais_q <= 1'b0;
      end
    end
  end

endmodule : e1rf_ais_detect

// ===== e1rf_crc_excess.sv
`timescale 1ns/1ps
module e1rf_crc_excess
  import e1rf_pkg::*;
#(
  parameter int WINDOW_CYCLES = SEC_CYCLES,
  parameter int ERR_LIMIT     = CRC_EXCESS_LIM
)(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // events
  input  wire logic crc_error,
  input  wire logic flag_read,
  // results
  output logic      excess_pulse_q,
  output logic      flag_q
);

  localparam int WW = $clog2(WINDOW_CYCLES);
  localparam int EW = $clog2(ERR_LIMIT + 1);

  logic [WW-1:0] win_cnt_q;
  logic [EW-1:0] err_cnt_q;
  logic          win_end;
  logic          hit;

  assign win_end = (win_cnt_q == WW'(WINDOW_CYCLES - 1));
  assign hit     = crc_error && (err_cnt_q == EW'(ERR_LIMIT - 1));

  always_ff @(posedge clk)
  begin
    if (reset || win_end)
      win_cnt_q <= '0;
    else
      win_cnt_q <= win_cnt_q + WW'(1);
  end

  // saturates at the limit so one second can only fire once
  always_ff @(posedge clk)
  begin
    if (reset || win_end)
      err_cnt_q <= '0;
    else if (crc_error && err_cnt_q != EW'(ERR_LIMIT))
      err_cnt_q <= err_cnt_q + EW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      excess_pulse_q <= 1'b0;
    else
      excess_pulse_q <= hit;
  end

  // a new hit wins over a read in the same cycle
  always_ff @(posedge clk)
  begin
    if (reset)
      flag_q <= 1'b0;
    else if (hit)
      flag_q <= 1'b1;
    else if (flag_read)
      flag_q <= 1'b0;
  end

endmodule : e1rf_crc_excess

// ===== e1rf_framer_ctrl_sva.sv
`timescale 1ns/1ps
module e1rf_framer_ctrl_sva
  import e1rf_pkg::*;
(
  // clock, reset and mode
  input wire logic       clk,
  input wire logic       reset,
  input wire logic       line_standard_select,
  input wire logic       unframed_select,
  // bus
  input wire logic       cs_n,
  input wire logic       wr_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  // far end
  input wire logic       a_bit_check,
  input wire logic       a_bit,
  // framer outputs
  input wire logic       irq_n_q,
  input wire logic       reframe_q,
  input wire logic       crc_mf_search_q,
  input wire logic       sig_mf_search_q,
  input wire logic       out_of_frame_q,
  input wire logic       remote_alarm_state_q,
  input wire logic       ais_q
);
  logic       held;
  logic       wr_prev_q;
  logic [7:0] opt_q;

  assign held = !line_standard_select || unframed_select;

  // shadow of the alignment options, taken on the strobe's first edge only
  always_ff @(posedge clk)
  begin
    wr_prev_q <= !cs_n && !wr_n;
    if (reset || held)
      opt_q <= ALIGN_OPT_RST;
    else if (!cs_n && !wr_n && !wr_prev_q && addr == ALIGN_OPT_ADDR)
      opt_q <= wdata;
  end

  default clocking dc @(posedge clk);
  endclocking
  default disable iff (reset);

  property p_pulse;
    reframe_q |=> !reframe_q;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("reframe request wider than one cycle");

  property p_force;
    $rose(opt_q[FORCE_FORCE_REFRAME_BIT]) |-> ##[1:3] reframe_q;
  endproperty
  a_force: assert property (p_force)
    else $error("forced reframe not issued");

  property p_oof;
    reframe_q |-> out_of_frame_q;
  endproperty
  a_oof: assert property (p_oof)
    else $error("reframe without out of frame");

  property p_crc;
    !opt_q[CRC_MF_EN_BIT] [*3] |-> !crc_mf_search_q;
  endproperty
  a_crc: assert property (p_crc)
    else $error("crc multiframe search while disabled");

  property p_sig;
    opt_q[SIG_MF_DIS_BIT] [*3] |-> !sig_mf_search_q;
  endproperty
  a_sig: assert property (p_sig)
    else $error("signaling multiframe search while disabled");

  property p_ais;
    $rose(ais_q) |-> $past(out_of_frame_q);
  endproperty
  a_ais: assert property (p_ais)
    else $error("alarm signal declared while in frame");

  property p_held;
    held [*3] |-> irq_n_q && out_of_frame_q && !ais_q;
  endproperty
  a_held: assert property (p_held)
    else $error("framer not held in reset");

  property p_rai_clr;
    a_bit_check && !a_bit && !held |=> !remote_alarm_state_q;
  endproperty
  a_rai_clr: assert property (p_rai_clr)
    else $error("remote alarm not cleared by zero");

  property p_rai_set;
    $rose(remote_alarm_state_q) |-> $past(a_bit_check && a_bit);
  endproperty
  a_rai_set: assert property (p_rai_set)
    else $error("remote alarm set without a one");

  c_reframe: cover property (reframe_q);
  c_ais: cover property ($rose(ais_q));
  c_rai: cover property ($rose(remote_alarm_state_q));

endmodule : e1rf_framer_ctrl_sva

bind e1rf_framer_ctrl e1rf_framer_ctrl_sva chk (.*);

// ===== e1rf_far_end.sv
`timescale 1ns/1ps
module e1rf_far_end (
  // clock
  input  wire logic clk,
  // event strobes
  output logic      frame_found,
  output logic      align_moved,
  output logic      fas_check,
  output logic      nfas_check,
  output logic      a_bit_check,
  output logic      smf_check,
  output logic      smf_found,
  output logic      cmf_check,
  output logic      cmf_found,
  output logic      crc_error,
  output logic      bit_valid,
  // qualifying data
  output logic      fas_err,
  output logic      bit2_err,
  output logic      a_bit,
  output logic      smf_err,
  output logic      ts16_zero,
  output logic      cmf_err,
  output logic      bit_data
);
  logic [10:0] strobe_q = '0;
  logic [6:0]  data_q = '0;

  assign {bit_valid, crc_error, cmf_found, cmf_check, smf_found, smf_check,
          a_bit_check, nfas_check, fas_check, align_moved,
          frame_found} = strobe_q;
  assign {bit_data, cmf_err, ts16_zero, smf_err, a_bit, bit2_err,
          fas_err} = data_q;

  // one strobe kind per call, back to back for n cycles
  task automatic send(input int k, input int n, input logic [6:0] d);
    repeat (n)
    begin
      @(posedge clk);
      strobe_q <= 11'h001 << k;
      data_q   <= d;
    end
    @(posedge clk);
    strobe_q <= '0;
    // released data shows the inverse, never a stale copy
    data_q   <= ~d;
  endtask : send

endmodule : e1rf_far_end

// ===== test_e1_receive_framer_control.sv
`timescale 1ns/1ps
module test_e1_receive_framer_control;
  import e1rf_pkg::*;
  localparam int FF = 0, AM = 1, FAS = 2, NFAS = 3, ABIT = 4;
  localparam int SMF = 5, CMF = 7, CRC = 9, BIT = 10;
  localparam logic [6:0] D_0 = 7'h00, D_FAS = 7'h01, D_B2 = 7'h02;
  localparam logic [6:0] D_A = 7'h04, D_SMF = 7'h08, D_CMF = 7'h20;
  localparam logic [6:0] D_ONE = 7'h40;
  localparam int K_EV [3] = '{AM, SMF, CMF};
  localparam logic [6:0] D_EV [3] = '{D_0, D_SMF, D_CMF};
  localparam logic [7:0] B_EV [3] = '{8'h08, 8'h02, 8'h01};

  logic       clk, reset, line_standard_select, unframed_select;
  logic       cs_n, rd_n, wr_n, data_oe_n_q, irq_n_q;
  logic [7:0] addr, wdata, rdata_q;
  logic       frame_found, align_moved, fas_check, fas_err, nfas_check;
  logic       bit2_err, a_bit_check, a_bit, smf_check, smf_err, ts16_zero;
  logic       smf_found, cmf_check, cmf_err, cmf_found, crc_error;
  logic       interwork_detect, bit_valid, bit_data, reframe_q;
  logic       crc_mf_search_q, sig_mf_search_q, out_of_frame_q;
  logic       remote_alarm_state_q, ais_q;
  int         failures, num_checks;

  e1rf_framer_ctrl #(.SEC_CNT(1000)) dut (.*);
  e1rf_far_end fe (.*);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic chkb(input string nm, input logic seen, exp);
    chk(nm, {7'h00, seen}, {7'h00, exp});
  endtask : chkb

  task automatic wr(input logic [7:0] a, d);
    @(posedge clk);
    cs_n  <= 1'b0;
    wr_n  <= 1'b0;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    cs_n  <= 1'b1;
    wr_n  <= 1'b1;
  endtask : wr

  task automatic rdc(input logic [7:0] a, m, e, input string nm);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk(nm, rdata_q & m, e);
    chkb("oe", data_oe_n_q, 1'b0);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
  endtask : rdc

  // outputs settle within three edges of an event; four gives margin
  task automatic st;
    repeat (4) @(posedge clk);
    #1;
  endtask : st

  task automatic report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (40000) @(posedge clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    failures = 0;
    num_checks = 0;
    reset = 1'b1;
    line_standard_select = 1'b1;
    unframed_select = 1'b0;
    {cs_n, rd_n, wr_n} = 3'h7;
    addr = 8'h00;
    wdata = 8'h00;
    interwork_detect = 1'b0;
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    rdc(ALIGN_OPT_ADDR, 8'hff, 8'h82, "aln");
    rdc(MAINT_OPT_ADDR, 8'hff, 8'h40, "mnt");
    rdc(8'h9f, 8'hff, 8'h00, "unmapped");
    wr(MAINT_OPT_ADDR, 8'hff);
    rdc(MAINT_OPT_ADDR, 8'hff, 8'h7a, "mnt_mask");
    for (int i = 0; i < 2; i++)
    begin
      wr(IRQ_EN_ADDR, 8'hff);
      line_standard_select <= (i == 1);
      unframed_select <= (i == 1);
      repeat (3) @(posedge clk);
      line_standard_select <= 1'b1;
      unframed_select <= 1'b0;
      rdc(IRQ_EN_ADDR, 8'hff, 8'h00, "held");
    end
    $display("test registers done");
    wr(IRQ_EN_ADDR, 8'h40);
    fe.send(FF, 1, D_0);
    st();
    chkb("irq", irq_n_q, 1'b0);
    rdc(IRQ_IND_ADDR, 8'h40, 8'h40, "ind_oof");
    st();
    chkb("irq_clr", irq_n_q, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      fe.send(K_EV[i], 1, D_EV[i]);
      st();
      chkb("irq_mask", irq_n_q, 1'b1);
      rdc(IRQ_IND_ADDR, B_EV[i], B_EV[i], "ind_ev");
    end
    fe.send(FAS, 3, D_FAS);
    st();
    chkb("oof", out_of_frame_q, 1'b1);
    rdc(IRQ_IND_ADDR, 8'h44, 8'h44, "ind_fer");
    $display("test interrupts done");
    // reserved alignment bit is never written as one
    wr(ALIGN_OPT_ADDR, 8'h81);
    fe.send(FF, 1, D_0);
    fe.send(FAS, 3, D_FAS);
    st();
    chkb("locked", out_of_frame_q, 1'b0);
    fe.send(BIT, 1024, D_ONE);
    st();
    chkb("ais_lock", ais_q, 1'b0);
    wr(ALIGN_OPT_ADDR, 8'h85);
    st();
    chkb("forced", out_of_frame_q, 1'b1);
    fe.send(FF, 1, D_0);
    wr(ALIGN_OPT_ADDR, 8'h85);
    st();
    chkb("no_edge", out_of_frame_q, 1'b0);
    wr(ALIGN_OPT_ADDR, 8'h81);
    wr(ALIGN_OPT_ADDR, 8'h85);
    fe.send(BIT, 512, D_ONE);
    st();
    chkb("ais", ais_q, 1'b1);
    wr(MAINT_OPT_ADDR, 8'h42);
    for (int i = 0; i < 4; i++)
    begin
      fe.send(BIT, 512, (i < 2) ? D_0 : D_ONE);
      st();
      chkb("ais_two", ais_q, 4'b1001 >> i);
    end
    $display("test reframe and alarm signal done");
    wr(ALIGN_OPT_ADDR, 8'h80);
    for (int i = 0; i < 2; i++)
    begin
      wr(MAINT_OPT_ADDR, (i == 0) ? 8'h40 : 8'h00);
      fe.send(FF, 1, D_0);
      fe.send(NFAS, 3, D_B2);
      st();
      chkb("bit2", out_of_frame_q, i == 0);
    end
    for (int i = 0; i < 5; i++)
    begin
      if (i == 2)
        wr(MAINT_OPT_ADDR, 8'h08);
      fe.send(ABIT, (i == 2) ? 3 : 1, (i == 1 || i == 4) ? D_0 : D_A);
      st();
      chkb("rai", remote_alarm_state_q, 5'b01001 >> i);
    end
    $display("test loss criteria done");
    for (int i = 0; i < 2; i++)
    begin
      wr(ALIGN_OPT_ADDR, (i == 0) ? 8'h82 : 8'h80);
      fe.send(FF, 1, D_0);
      fe.send(CRC, 2000, D_0);
      st();
      chkb("crc_force_reframe", out_of_frame_q, i == 0);
      rdc(MAINT_OPT_ADDR, 8'h01, 8'h01, "excess");
    end
    rdc(MAINT_OPT_ADDR, 8'h01, 8'h00, "excess_rd");
    wr(ALIGN_OPT_ADDR, 8'h00);
    fe.send(CRC, 2000, D_0);
    st();
    rdc(MAINT_OPT_ADDR, 8'h01, 8'h00, "excess_off");
    wr(ALIGN_OPT_ADDR, 8'hc2);
    st();
    chkb("sig_off", sig_mf_search_q, 1'b0);
    $display("test crc excess done");
    wr(ALIGN_OPT_ADDR, 8'h84);
    fe.send(FF, 1, D_0);
    interwork_detect <= 1'b1;
    for (int i = 0; i < 2; i++)
    begin
      wr(ALIGN_OPT_ADDR, (i == 0) ? 8'h80 : 8'ha0);
      st();
      chkb("iw_search", crc_mf_search_q, i == 1);
    end
    wr(MAINT_OPT_ADDR, 8'h30);
    fe.send(SMF + 1, 1, D_0);
    for (int i = 0; i < 2; i++)
    begin
      fe.send(SMF, 1, 7'h10);
      st();
      chkb("ts16", sig_mf_search_q, i == 1);
    end
    $display("test multiframe search done");
    report_and_stop();
  end

endmodule : test_e1_receive_framer_control
